// ===== include/wssq_consts.vh
`ifndef WSSQ_CONSTS_VH
`define WSSQ_CONSTS_VH
`define WSSQ_CLK_HZ          10000000
`define WSSQ_XTAL_HZ         32768
`define WSSQ_RESET_DLY_TICKS 50463
`define WSSQ_START_DLY_TICKS 1024
`define WSSQ_ALERT_DLY_TICKS 256
`define WSSQ_STOP_DLY_TICKS  64
`define WSSQ_SUPPLY_DLY_TICKS 96
`define WSSQ_WAKE_MIN_NS     1000
`define WSSQ_CLK_NS          100
`define WSSQ_WAKE_CYCLES     ((`WSSQ_WAKE_MIN_NS + `WSSQ_CLK_NS - 1) / `WSSQ_CLK_NS)
`define WSSQ_FAST_DIV        2
`endif

// ===== src/wssq_sync.v
`timescale 1ns/10ps
`default_nettype none
module wssq_sync #(
  parameter RST_VAL = 1'b1
) (
  input  wire clk_sys,
  input  wire nrst,
  input  wire d_in,
  output reg  q_out
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      q_out  <= RST_VAL;
    end else begin
      s1_reg <= d_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        q_out <= s3_reg;
      end
    end
  end
endmodule // wssq_sync
`default_nettype wire

// ===== src/wssq_sequencer.v
`timescale 1ns/10ps
`default_nettype none
`include "wssq_consts.vh"
module wssq_sequencer #(
  parameter RESET_DLY_TICKS  = `WSSQ_RESET_DLY_TICKS,
  parameter START_DLY_TICKS  = `WSSQ_START_DLY_TICKS,
  parameter ALERT_DLY_TICKS  = `WSSQ_ALERT_DLY_TICKS,
  parameter STOP_DLY_TICKS   = `WSSQ_STOP_DLY_TICKS,
  parameter SUPPLY_DLY_TICKS = `WSSQ_SUPPLY_DLY_TICKS,
  parameter FAST_DIV         = `WSSQ_FAST_DIV
) (
  input  wire clk_sys,
  input  wire nrst,
  input  wire xtal_tick,
  input  wire supply_above_high,
  input  wire supply_above_low,
  input  wire monitor_threshold_select,
  input  wire low_voltage_ok,
  input  wire pll_enable,
  input  wire shutdown_cmd,
  input  wire wake_input_a_n,
  input  wire wake_input_b_n,
  output reg  monitor_reset_n_out,
  output reg  monitor_reset_n_oe,
  output reg  supply_off_out,
  output reg  fast_clock_out,
  output reg  alert_n_out,
  output reg  standby_state
);
  localparam ST_SLEEP   = 5'b00001;
  localparam ST_STANDBY = 5'b00010;
  localparam ST_WAIT    = 5'b00100;
  localparam ST_RUN     = 5'b01000;
  localparam ST_STOP    = 5'b10000;
  localparam WAKE_CYC   = `WSSQ_WAKE_CYCLES;

  wire       wa_sync;
  wire       wb_sync;
  wire       sup_sync;
  reg        sup_hi_reg;
  reg  [4:0] state_reg;
  reg  [4:0] state_next;
  reg  [15:0] rst_cnt_reg;
  reg  [15:0] tick_cnt_reg;
  reg  [7:0] wake_cnt_reg;
  reg  [7:0] fdiv_reg;
  reg        wake_ok;
  reg        shut_reg;
  reg        shut_seen_reg;
  wire       gate_ok;

  wssq_sync #(.RST_VAL(1'b1)) u_wa (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .d_in    (wake_input_a_n),
    .q_out   (wa_sync)
  );
  wssq_sync #(.RST_VAL(1'b1)) u_wb (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .d_in    (wake_input_b_n),
    .q_out   (wb_sync)
  );
  wssq_sync #(.RST_VAL(1'b0)) u_sup (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .d_in    (monitor_threshold_select ? supply_above_low : supply_above_high),
    .q_out   (sup_sync)
  );

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_cnt_reg         <= 16'h0000;
      monitor_reset_n_out <= 1'b0;
      monitor_reset_n_oe  <= 1'b1;
      sup_hi_reg          <= 1'b0;
    end else begin
      sup_hi_reg <= sup_sync;
      if (!sup_sync) begin
        rst_cnt_reg         <= 16'h0000;
        monitor_reset_n_oe  <= 1'b1;
      end else if (monitor_reset_n_oe) begin
        if (xtal_tick) begin
          if (rst_cnt_reg >= RESET_DLY_TICKS - 1) begin
            monitor_reset_n_oe <= 1'b0;
          end else begin
            rst_cnt_reg <= rst_cnt_reg + 16'h0001;
          end
        end
      end
      monitor_reset_n_out <= 1'b0;
    end
  end

  assign gate_ok = !monitor_reset_n_oe && low_voltage_ok && pll_enable;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wake_cnt_reg <= 8'h00;
      wake_ok      <= 1'b0;
    end else begin
      wake_ok <= 1'b0;
      if (wa_sync && wb_sync) begin
        wake_cnt_reg <= 8'h00;
      end else if (wake_cnt_reg < WAKE_CYC - 1) begin
        wake_cnt_reg <= wake_cnt_reg + 8'h01;
      end else begin
        wake_ok <= 1'b1;
      end
    end
  end

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_SLEEP:   if (wake_ok) state_next = ST_STANDBY;
      ST_STANDBY: if (gate_ok) state_next = ST_WAIT;
      ST_WAIT: begin
        if (!gate_ok) state_next = ST_STANDBY;
        else if (xtal_tick && tick_cnt_reg >= START_DLY_TICKS - 1) state_next = ST_RUN;
      end
      ST_RUN:     if (shut_reg) state_next = ST_STOP;
      ST_STOP: begin
        if (xtal_tick && tick_cnt_reg >= SUPPLY_DLY_TICKS - 1 && !pll_enable)
          state_next = ST_SLEEP;
      end
      default:    state_next = ST_SLEEP;
    endcase
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg     <= ST_SLEEP;
      tick_cnt_reg  <= 16'h0000;
      shut_reg      <= 1'b0;
      shut_seen_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      shut_seen_reg <= shutdown_cmd;
      if (state_reg == ST_RUN && shutdown_cmd && !shut_seen_reg) begin
        shut_reg <= 1'b1;
      end else if (state_reg != ST_RUN) begin
        shut_reg <= 1'b0;
      end
      if (state_next != state_reg) begin
        tick_cnt_reg <= 16'h0000;
      end else if (xtal_tick && tick_cnt_reg != 16'hFFFF) begin
        tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      end
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      supply_off_out <= 1'b0;
      standby_state  <= 1'b0;
    end else begin
      standby_state <= (state_next != ST_SLEEP);
      if (state_next == ST_SLEEP) begin
        supply_off_out <= 1'b0;
      end else if (state_next == ST_STOP && state_reg == ST_STOP &&
                   tick_cnt_reg >= SUPPLY_DLY_TICKS - 1 && !pll_enable) begin
        supply_off_out <= 1'b0;
      end else begin
        supply_off_out <= 1'b1;
      end
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fdiv_reg       <= 8'h00;
      fast_clock_out <= 1'b0;
      alert_n_out    <= 1'b1;
    end else begin
      if (state_reg == ST_RUN ||
          (state_reg == ST_STOP && tick_cnt_reg < STOP_DLY_TICKS)) begin
        if (fdiv_reg >= FAST_DIV - 1) begin
          fdiv_reg       <= 8'h00;
          fast_clock_out <= !fast_clock_out;
        end else begin
          fdiv_reg <= fdiv_reg + 8'h01;
        end
      end else begin
        fdiv_reg       <= 8'h00;
        fast_clock_out <= 1'b0;
      end
      if (state_reg == ST_RUN && tick_cnt_reg >= ALERT_DLY_TICKS) begin
        alert_n_out <= 1'b0;
      end else if (state_reg != ST_RUN) begin
        alert_n_out <= 1'b1;
      end
    end
  end
endmodule // wssq_sequencer
`default_nettype wire

// ===== verification/wssq_checker.sv
`timescale 1ns/10ps
`default_nettype none
module wssq_checker (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic supply_above_high,
  input wire logic supply_above_low,
  input wire logic monitor_threshold_select,
  input wire logic low_voltage_ok,
  input wire logic pll_enable,
  input wire logic wake_input_a_n,
  input wire logic wake_input_b_n,
  input wire logic monitor_reset_n_oe,
  input wire logic supply_off_out,
  input wire logic fast_clock_out,
  input wire logic alert_n_out,
  input wire logic standby_state
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_sleep_supply_off: assert property (
    !standby_state |-> !supply_off_out) else $error("supply on in sleep");
  a_pll_holds_supply: assert property (
    pll_enable && supply_off_out |=> supply_off_out) else $error("supply dropped");
  a_supply_fall_cause: assert property (
    $fell(supply_off_out) |-> !$past(pll_enable)) else $error("supply fell early");
  a_clock_gate_ok: assert property (
    $rose(fast_clock_out) |-> $past(pll_enable) && $past(low_voltage_ok)
      && !$past(monitor_reset_n_oe)) else $error("clock not gated");
  a_clock_low_start: assert property (
    $rose(fast_clock_out) |-> !$past(fast_clock_out, 2)) else $error("clock start");
  a_alert_when_run: assert property (
    $fell(alert_n_out) |-> pll_enable && standby_state) else $error("alert early");
  a_wake_a_supply: assert property (
    $fell(wake_input_a_n) ##1 !wake_input_a_n[*8] |-> ##[0:12] supply_off_out)
    else $error("no supply on wake");
  a_wake_b_standby: assert property (
    $fell(wake_input_b_n) ##1 !wake_input_b_n[*8] |-> ##[0:12] standby_state)
    else $error("no standby on wake");
  a_reset_release_ok: assert property (
    $fell(monitor_reset_n_oe) |-> (monitor_threshold_select ? supply_above_low
      : supply_above_high)) else $error("reset released low");
endmodule // wssq_checker
bind wssq_sequencer wssq_checker u_chk (.*);
`default_nettype wire

// ===== verification/wssq_host.sv
`timescale 1ns/10ps
`default_nettype none
module wssq_host (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic run_req,
  input  wire logic sleep_req,
  output var  logic pll_enable,
  output var  logic shutdown_cmd
);
  int hold;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hold <= 0;
      pll_enable <= 1'h0;
      shutdown_cmd <= 1'h0;
    end else begin
      hold <= sleep_req ? hold + 1 : 0;
      shutdown_cmd <= sleep_req;
      pll_enable <= run_req && hold < 40;
    end
  end
endmodule // wssq_host
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_sys, nrst, xtal_tick, supply_above_high, supply_above_low;
  logic monitor_threshold_select, low_voltage_ok, run_req, sleep_req;
  logic wake_input_a_n, wake_input_b_n;
  logic seen;
  wire  pll_enable, shutdown_cmd, monitor_reset_n_out, monitor_reset_n_oe;
  wire  supply_off_out, fast_clock_out, alert_n_out, standby_state;
  wire [6:0] outs = {seen, monitor_reset_n_out, standby_state, alert_n_out, fast_clock_out,
    supply_off_out, monitor_reset_n_oe};
  int miscompares = 0, checks = 0, cyc = 0, n;
  wssq_sequencer #(.RESET_DLY_TICKS(4), .START_DLY_TICKS(8), .ALERT_DLY_TICKS(4),
    .STOP_DLY_TICKS(2), .SUPPLY_DLY_TICKS(3), .FAST_DIV(2)) dut (.*);
  wssq_host host (.*);
  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    xtal_tick <= (cyc % 4 == 3);
    if (cyc == 3000) begin
      miscompares++;
      results();
    end
  end
  task automatic meas(int i, logic v);
    n = 0;
    while (outs[i] !== v && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
  endtask
  task automatic rng(string s, int lo, int hi);
    checks++;
    if (n < lo || n > hi) begin
      miscompares++;
      $display("Error %s expected %0d..%0d seen %0d", s, lo, hi, n);
    end
  endtask
  task automatic chk(string s, logic e, int i);
    @(negedge clk_sys);
    checks++;
    if (outs[i] !== e) begin
      miscompares++;
      $display("Error %s expected %b seen %b", s, e, outs[i]);
    end
  endtask
  task automatic go(int c);
    repeat (c) @(posedge clk_sys);
  endtask
  task automatic results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    nrst <= 1'h0;
    supply_above_high <= 1'h0;
    supply_above_low <= 1'h0;
    monitor_threshold_select <= 1'h0;
    low_voltage_ok <= 1'h0;
    run_req <= 1'h0;
    sleep_req <= 1'h0;
    wake_input_a_n <= 1'h1;
    wake_input_b_n <= 1'h1;
    seen = 1'h0;
    go(2);
    nrst <= 1'h1;
    supply_above_low <= 1'h1;
    go(40);
    chk("reset held", 1'h1, 0);
    chk("reset pin", 1'h0, 5);
    go(1);
    monitor_threshold_select <= 1'h1;
    meas(0, 1'h0);
    rng("reset release", 12, 28);
    go(1);
    supply_above_high <= 1'h1;
    wake_input_a_n <= 1'h0;
    meas(1, 1'h1);
    rng("wake to supply", 1, 20);
    go(10);
    wake_input_a_n <= 1'h1;
    chk("standby", 1'h1, 4);
    go(1);
    run_req <= 1'h1;
    go(60);
    chk("clock gated", 1'h0, 2);
    go(1);
    low_voltage_ok <= 1'h1;
    meas(2, 1'h1);
    rng("clock start", 28, 44);
    meas(3, 1'h0);
    rng("alert delay", 12, 24);
    go(1);
    sleep_req <= 1'h1;
    go(16);
    seen = 1'h0;
    repeat (8) begin
      @(negedge clk_sys);
      seen = seen | fast_clock_out;
    end
    chk("clock stopped", 1'h0, 6);
    chk("supply held", 1'h1, 1);
    meas(1, 1'h0);
    rng("supply off", 10, 36);
    meas(4, 1'h0);
    rng("sleep entry", 0, 4);
    chk("sleep", 1'h0, 4);
    chk("sleep supply", 1'h0, 1);
    go(1);
    run_req <= 1'h0;
    sleep_req <= 1'h0;
    wake_input_b_n <= 1'h0;
    meas(4, 1'h1);
    rng("wake b", 1, 20);
    go(10);
    wake_input_b_n <= 1'h1;
    results();
  end
endmodule // tb_top
`default_nettype wire
